// ### rtl/counter_array_timebase.sv
// shared 16-bit time base of a five-module counter array with its two registers
// assumes core clock I_MCLK is the oscillator; module events and timer 0
// overflow come as one-cycle pulses from logic on the same clock
//
// Function
// [R1] source 00 counts at clock/12 (clock/6 double speed), 01 at clock/4 (clock/2).
// [R2] source 10 counts timer 0 overflows, 11 the external pin, whose rate must stay under clock/8.
// [R3] one 16-bit counter is the common time base of all five modules.
// [R4] idle gating 0 keeps counting in idle, 1 stops the counter while idle.
// [R5] the watchdog enable bit turns the module 4 watchdog on or off.
// [R6] the overflow interrupt enable lets the overflow flag request the interrupt; the flag sets regardless.
// [R7] the counter runs only while run control, control bit 6, is 1.
// [R8] overflow sets control bit 7; only a software write of 0 clears it.
// [R9] control bits 0 to 4 are module flags set by hardware and cleared only by software.
// [R10] all five module requests and the overflow merge into one interrupt request.
// [R11] external count is port 1 bit 2, module pins port 1 bits 3 to 7, else plain port pins.
// [R12] implemented control bits reset to 0; unimplemented bits read back undefined.
// [R13] software writes only 0 to unimplemented bits.
// [R14] software may set the overflow flag by writing 1, with the same interrupt effect.
// [R15] a module flag requests the interrupt only while that module's enable bit is 1.
// [R16] the counter steps by one per count pulse and wraps to zero, setting the overflow flag.
// [R17] the external pin is synchronised and each falling edge gives exactly one count pulse.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module counter_array_timebase
    import timebase_pkg::*;
(
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    // wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [11:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // system side
    input wire logic I_DOUBLE_SPEED_MODE,
    input wire logic I_CPU_IDLE,
    input wire logic I_TIMER0_OVERFLOW,
    input wire logic I_EXTERNAL_COUNT_INPUT,
    // compare/capture modules
    input wire logic [timebase_pkg::NUM_MODULES-1:0] I_MODULE_EVENT,
    input wire logic [timebase_pkg::NUM_MODULES-1:0] I_MODULE_IRQ_ENABLE,
    input wire logic [timebase_pkg::NUM_MODULES-1:0] I_MODULE_PIN_USED,
    output logic [15:0] O_COUNT,
    output logic O_MODULE4_WATCHDOG_ENABLE,
    output logic [7:0] O_PORT1_ALT_SELECT,
    // interrupts
    output logic O_ARRAY_IRQ,
    output logic O_EVENT_IRQ
);
    import timebase_pkg::*;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ---------------------------------------------------------------
    // external pin synchroniser
    // ---------------------------------------------------------------
    logic ext_meta_reg, ext_sync_reg, ext_prev_reg;
    logic ext_fall;

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta_reg <= 1'b1;
            ext_sync_reg <= 1'b1;
            ext_prev_reg <= 1'b1;
        end else begin
            ext_meta_reg <= I_EXTERNAL_COUNT_INPUT;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end
    // one pulse per falling edge, read only past the second flop
    assign ext_fall = ext_prev_reg & ~ext_sync_reg; // [R17]

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic [9:0] word_idx;
    logic req, wr_fire, wr_ctrl, wr_mode, wr_en, wr_clr;

    assign word_idx = I_WB_ADR[11:2];
    assign req = I_WB_CYC & I_WB_STB;
    // write acts on the edge at which the master sees ack
    assign wr_fire = req & I_WB_WE & O_WB_ACK & I_WB_SEL[0];
    assign wr_ctrl = wr_fire & (word_idx == CTRL_FLAGS_IDX);
    assign wr_mode = wr_fire & (word_idx == CNT_MODE_IDX);
    assign wr_en = wr_fire & (word_idx == EVT_ENABLE_IDX);
    assign wr_clr = wr_fire & (word_idx == EVT_CLEAR_IDX);

    // ---------------------------------------------------------------
    // time base state
    // ---------------------------------------------------------------
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] mode_reg, mode_next;
    logic [15:0] count_reg, count_next;
    logic [3:0] pre_reg, pre_next;
    logic [3:0] period;
    logic count_en, pulse, wrap;
    count_src_t src;

    assign src = count_src_t'({mode_reg[SRC_HI_BIT], mode_reg[SRC_LO_BIT]});
    assign count_en = ctrl_reg[RUN_BIT] // [R7]
        & ~(mode_reg[IDLE_GATE_BIT] & I_CPU_IDLE); // [R4]

    always_comb begin
        // prescaler period follows source and double speed
        if (src == SRC_DIV_SLOW) begin
            period = I_DOUBLE_SPEED_MODE ? DIV_SLOW_X2 : DIV_SLOW; // [R1]
        end else begin
            period = I_DOUBLE_SPEED_MODE ? DIV_FAST_X2 : DIV_FAST; // [R1]
        end
        pre_next = pre_reg;
        pulse = 1'b0;
        case (src)
            SRC_DIV_SLOW, SRC_DIV_FAST: begin
                if (count_en) begin
                    if (pre_reg >= period - 4'h1) begin
                        pre_next = 4'h0;
                        pulse = 1'b1;
                    end else begin
                        pre_next = pre_reg + 4'h1;
                    end
                end
            end
            SRC_TIMER0: begin
                pulse = count_en & I_TIMER0_OVERFLOW; // [R2]
            end
            SRC_EXTERNAL: begin
                pulse = count_en & ext_fall; // [R2]
            end
            default: begin
                pulse = 1'b0;
            end
        endcase
        wrap = pulse & (count_reg == COUNT_MAX);
        count_next = pulse ? count_reg + 16'h0001 : count_reg; // [R3] [R16]

        mode_next = mode_reg;
        if (wr_mode) begin
            // unimplemented bits are not stored
            mode_next = {I_WB_DAT[7:6], 3'h0, I_WB_DAT[2:0]};
        end

        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next[OVF_FLAG_BIT] = I_WB_DAT[OVF_FLAG_BIT]; // [R14]
            ctrl_next[RUN_BIT] = I_WB_DAT[RUN_BIT];
            // module flags: a written 0 clears, a written 1 leaves alone
            ctrl_next[NUM_MODULES-1:0] = ctrl_reg[NUM_MODULES-1:0] & I_WB_DAT[NUM_MODULES-1:0]; // [R9]
        end
        // hardware sets win over a clear in the same cycle
        if (wrap) begin
            ctrl_next[OVF_FLAG_BIT] = 1'b1; // [R8] [R16]
        end
        ctrl_next[NUM_MODULES-1:0] = ctrl_next[NUM_MODULES-1:0] | I_MODULE_EVENT; // [R9]
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_FLAGS_RST; // [R12]
            mode_reg <= CNT_MODE_RST; // [R12]
            count_reg <= COUNT_RST;
            pre_reg <= 4'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            mode_reg <= mode_next;
            count_reg <= count_next;
            pre_reg <= pre_next;
        end
    end

    // ---------------------------------------------------------------
    // event status, enable and interrupt outputs
    // ---------------------------------------------------------------
    logic [5:0] evt_reg, evt_next, evt_en_reg, evt_en_next;
    logic [5:0] evt_raw;
    logic array_irq_next, event_irq_next;
    logic [7:0] alt_next;

    assign evt_raw = {wrap, I_MODULE_EVENT};

    always_comb begin
        evt_en_next = wr_en ? I_WB_DAT[5:0] : evt_en_reg;
        // clear first, then set, so a new event is never lost
        evt_next = (wr_clr ? evt_reg & ~I_WB_DAT[5:0] : evt_reg) | evt_raw;
        array_irq_next = (ctrl_reg[OVF_FLAG_BIT] & mode_reg[OVF_IRQ_EN_BIT]) // [R6] [R10]
            | (|(ctrl_reg[NUM_MODULES-1:0] & I_MODULE_IRQ_ENABLE)); // [R15] [R10]
        event_irq_next = |(evt_reg & evt_en_reg);
        alt_next = 8'h00;
        alt_next[EXT_PIN_BIT] = (src == SRC_EXTERNAL); // [R11]
        alt_next[MOD_PIN_BASE +: NUM_MODULES] = I_MODULE_PIN_USED; // [R11]
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            evt_reg <= EVT_RST;
            evt_en_reg <= EVT_RST;
            O_ARRAY_IRQ <= 1'b0;
            O_EVENT_IRQ <= 1'b0;
            O_PORT1_ALT_SELECT <= 8'h00;
            O_COUNT <= COUNT_RST;
            O_MODULE4_WATCHDOG_ENABLE <= 1'b0;
        end else begin
            evt_reg <= evt_next;
            evt_en_reg <= evt_en_next;
            O_ARRAY_IRQ <= array_irq_next;
            O_EVENT_IRQ <= event_irq_next;
            O_PORT1_ALT_SELECT <= alt_next;
            O_COUNT <= count_next; // [R3]
            O_MODULE4_WATCHDOG_ENABLE <= mode_next[WDOG_EN_BIT]; // [R5]
        end
    end

    // ---------------------------------------------------------------
    // bus answer
    // ---------------------------------------------------------------
    logic ack_next;
    logic [31:0] rdat_next;

    always_comb begin
        ack_next = req & ~O_WB_ACK;
        rdat_next = 32'h0000_0000;
        // unimplemented bits and unmapped words read zero
        case (word_idx)
            CTRL_FLAGS_IDX: rdat_next[7:0] = ctrl_reg;
            CNT_MODE_IDX: rdat_next[7:0] = mode_reg;
            EVT_STATUS_IDX: rdat_next[5:0] = evt_reg;
            EVT_ENABLE_IDX: rdat_next[5:0] = evt_en_reg;
            default: rdat_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h0000_0000;
        end else begin
            O_WB_ACK <= ack_next;
            O_WB_DAT <= rdat_next;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    prescale_period_a: assert property ( // [R1]
        @(posedge I_MCLK) disable iff (!rst_n)
        (src == SRC_DIV_FAST && !I_DOUBLE_SPEED_MODE && pulse)
        |-> ##1 (!pulse && src == SRC_DIV_FAST && !I_DOUBLE_SPEED_MODE && count_en) [*3] ##1 pulse
        or ##[1:4] !(src == SRC_DIV_FAST && !I_DOUBLE_SPEED_MODE && count_en))
        else $error("fast prescaler period is not four clocks");

    timer0_count_a: assert property ( // [R2]
        @(posedge I_MCLK) disable iff (!rst_n)
        (src == SRC_TIMER0 && count_en && I_TIMER0_OVERFLOW)
        |=> O_COUNT == $past(count_reg) + 16'h0001)
        else $error("timer 0 overflow did not advance the counter");

    ext_edge_a: assert property ( // [R17]
        @(posedge I_MCLK) disable iff (!rst_n)
        (src == SRC_EXTERNAL && count_en && $fell(ext_sync_reg))
        |=> (count_reg != $past(count_reg)) ##1 (count_reg == $past(count_reg)))
        else $error("external falling edge did not give one count");

    idle_stop_a: assert property ( // [R4]
        @(posedge I_MCLK) disable iff (!rst_n)
        (mode_reg[IDLE_GATE_BIT] && I_CPU_IDLE) |=> $stable(count_reg))
        else $error("counter moved while gated in idle");

    run_stop_a: assert property ( // [R7]
        @(posedge I_MCLK) disable iff (!rst_n)
        !ctrl_reg[RUN_BIT] |=> $stable(count_reg))
        else $error("counter moved with run control clear");

    step_wrap_a: assert property ( // [R16]
        @(posedge I_MCLK) disable iff (!rst_n)
        (count_reg != $past(count_reg)) |-> (count_reg == $past(count_reg) + 16'h0001))
        else $error("counter did not step by one");

    overflow_set_a: assert property ( // [R8]
        @(posedge I_MCLK) disable iff (!rst_n)
        (pulse && count_reg == COUNT_MAX) |=> (ctrl_reg[OVF_FLAG_BIT] && count_reg == COUNT_RST))
        else $error("wrap did not set the overflow flag");

    overflow_hold_a: assert property ( // [R8]
        @(posedge I_MCLK) disable iff (!rst_n)
        (ctrl_reg[OVF_FLAG_BIT] && !wr_ctrl) |=> ctrl_reg[OVF_FLAG_BIT])
        else $error("overflow flag cleared without a write");

    module_flag_a: assert property ( // [R9]
        @(posedge I_MCLK) disable iff (!rst_n)
        I_MODULE_EVENT[4] |=> ctrl_reg[4] ##1 (ctrl_reg[4] || $past(wr_ctrl)))
        else $error("module 4 flag not held after its event");

    shared_irq_a: assert property ( // [R10]
        @(posedge I_MCLK) disable iff (!rst_n)
        O_ARRAY_IRQ == $past((ctrl_reg[OVF_FLAG_BIT] & mode_reg[OVF_IRQ_EN_BIT])
            | (|(ctrl_reg[NUM_MODULES-1:0] & I_MODULE_IRQ_ENABLE))))
        else $error("shared interrupt does not follow its causes");

    watchdog_en_a: assert property ( // [R5]
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_mode |=> O_MODULE4_WATCHDOG_ENABLE == $past(I_WB_DAT[WDOG_EN_BIT]))
        else $error("watchdog enable does not follow the mode write");

    slow_x2_period_a: assert property ( // [R1]
        @(posedge I_MCLK) disable iff (!rst_n)
        (src == SRC_DIV_SLOW && I_DOUBLE_SPEED_MODE && pulse)
        |-> ##1 (!pulse && src == SRC_DIV_SLOW && I_DOUBLE_SPEED_MODE && count_en) [*5] ##1 pulse
        or ##[1:6] !(src == SRC_DIV_SLOW && I_DOUBLE_SPEED_MODE && count_en))
        else $error("double speed slow prescaler period is not six clocks");

    ovf_irq_a: assert property ( // [R6]
        @(posedge I_MCLK) disable iff (!rst_n)
        (ctrl_reg[OVF_FLAG_BIT] && mode_reg[OVF_IRQ_EN_BIT]) |=> O_ARRAY_IRQ)
        else $error("enabled overflow flag raised no interrupt");

    irq_quiet_a: assert property ( // [R6] [R15]
        @(posedge I_MCLK) disable iff (!rst_n)
        (!mode_reg[OVF_IRQ_EN_BIT] && !(|(ctrl_reg[NUM_MODULES-1:0] & I_MODULE_IRQ_ENABLE))) |=> !O_ARRAY_IRQ)
        else $error("interrupt raised with every cause masked");

    module_hold_a: assert property ( // [R9]
        @(posedge I_MCLK) disable iff (!rst_n)
        (ctrl_reg[0] && !wr_ctrl) |=> ctrl_reg[0])
        else $error("module 0 flag cleared without a write");

endmodule

`default_nettype wire

// ### rtl/timebase_pkg.sv
// constants of the counter array time base: register indices, fields, resets
// assumes a 32-bit classic wishbone slave with one register per aligned word
package timebase_pkg;

    // ---------------------------------------------------------------
    // register indices, byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [9:0] CTRL_FLAGS_IDX = 10'h0d8;
    localparam logic [9:0] CNT_MODE_IDX = 10'h0d9;
    localparam logic [9:0] EVT_STATUS_IDX = 10'h0e0;
    localparam logic [9:0] EVT_ENABLE_IDX = 10'h0e1;
    localparam logic [9:0] EVT_CLEAR_IDX = 10'h0e2;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int OVF_FLAG_BIT = 7;
    localparam int RUN_BIT = 6;
    localparam int IDLE_GATE_BIT = 7;
    localparam int WDOG_EN_BIT = 6;
    localparam int SRC_HI_BIT = 2;
    localparam int SRC_LO_BIT = 1;
    localparam int OVF_IRQ_EN_BIT = 0;
    localparam int EXT_PIN_BIT = 2;
    localparam int MOD_PIN_BASE = 3;
    localparam int EVT_OVF_BIT = 5;
    localparam int NUM_MODULES = 5;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_FLAGS_RST = 8'h00;
    localparam logic [7:0] CNT_MODE_RST = 8'h00;
    localparam logic [5:0] EVT_RST = 6'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    // ---------------------------------------------------------------
    // count sources and prescaler periods in core clocks
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_DIV_SLOW,
        SRC_DIV_FAST,
        SRC_TIMER0,
        SRC_EXTERNAL
    } count_src_t;

    localparam logic [3:0] DIV_SLOW = 4'hc;
    localparam logic [3:0] DIV_SLOW_X2 = 4'h6;
    localparam logic [3:0] DIV_FAST = 4'h4;
    localparam logic [3:0] DIV_FAST_X2 = 4'h2;

endpackage

// ### test/tb.sv
// self-checking bench for the counter array time base
// assumes the design package is compiled first; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none

module tb;
    import timebase_pkg::*;

    typedef struct packed {
        logic [7:0] mode;
        logic x2;
        logic [4:0] period;
    } row_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic x2 = 1'b0;
    logic idle = 1'b0;
    logic t0 = 1'b0;
    logic ext = 1'b1;
    logic [4:0] mev = 5'h00;
    logic [4:0] mien = 5'h00;
    logic [4:0] pused = 5'h15;
    logic [15:0] cnt;
    logic wdog;
    logic [7:0] alt;
    logic airq;
    logic eirq;
    logic [15:0] snap;
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    row_t rows [4] = '{'{8'h00, 1'b0, 5'h0c}, '{8'h00, 1'b1, 5'h06}, '{8'h02, 1'b0, 5'h04}, '{8'h42, 1'b1, 5'h02}};

    always #2 clk = ~clk;

    counter_array_timebase u_dut (
        .I_MCLK(clk), .I_RESET_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_DOUBLE_SPEED_MODE(x2), .I_CPU_IDLE(idle), .I_TIMER0_OVERFLOW(t0),
        .I_EXTERNAL_COUNT_INPUT(ext), .I_MODULE_EVENT(mev), .I_MODULE_IRQ_ENABLE(mien),
        .I_MODULE_PIN_USED(pused), .O_COUNT(cnt), .O_MODULE4_WATCHDOG_ENABLE(wdog),
        .O_PORT1_ALT_SELECT(alt), .O_ARRAY_IRQ(airq), .O_EVENT_IRQ(eirq)
    );

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request stands until the edge that samples ack high; read data taken there
    // no wait limit here: only the watchdog ends a hung transfer
    task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h1;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, idx, d, r);
    endtask

    task automatic rd(input string what, input logic [9:0] idx, input logic [7:0] e);
        logic [7:0] r;
        wb(1'b0, idx, 8'h00, r);
        chk(what, {8'h00, e}, {8'h00, r});
    endtask

    task automatic pulse_t0();
        @(posedge clk) t0 <= 1'b1;
        @(posedge clk) t0 <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // cycles between two successive counter steps
    task automatic period_of(output int p);
        logic [15:0] c;
        int k;
        k = 0;
        @(negedge clk);
        c = cnt;
        while (cnt === c && k < 100) begin
            @(negedge clk);
            k++;
        end
        c = cnt;
        p = 0;
        do begin
            @(negedge clk);
            p++;
        end while (cnt === c && p < 100);
    endtask

    task automatic hold_check(input string what);
        @(negedge clk);
        snap = cnt;
        repeat (20) @(negedge clk);
        chk(what, snap, cnt);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("count", COUNT_RST, cnt);
        chk("irq", 16'h0, {15'h0, airq});
        rd("ctrl", CTRL_FLAGS_IDX, CTRL_FLAGS_RST);
        rd("mode", CNT_MODE_IDX, CNT_MODE_RST);
        rd("unmapped", 10'h0f0, 8'h00);
        wr(CTRL_FLAGS_IDX, 8'h40);
        foreach (rows[i]) begin
            @(posedge clk) x2 <= rows[i].x2;
            wr(CNT_MODE_IDX, rows[i].mode);
            rd("mode", CNT_MODE_IDX, rows[i].mode);
            period_of(n);
            chk("period", {11'h0, rows[i].period}, n[15:0]);
            chk("wdog", {15'h0, rows[i].mode[WDOG_EN_BIT]}, {15'h0, wdog});
            chk("alt", {8'h0, pused, 3'b000}, {8'h0, alt});
        end
        // idle gating on, then off, then run control off
        wr(CNT_MODE_IDX, 8'h82);
        @(posedge clk) idle <= 1'b1;
        hold_check("idle count");
        wr(CNT_MODE_IDX, 8'h02);
        @(negedge clk);
        snap = cnt;
        repeat (20) @(negedge clk);
        chk("idle run", 16'h1, {15'h0, cnt !== snap});
        @(posedge clk) idle <= 1'b0;
        wr(CTRL_FLAGS_IDX, 8'h00);
        hold_check("stopped");
        wr(CTRL_FLAGS_IDX, 8'h40);
        // timer 0 and external pin sources, one step each
        wr(CNT_MODE_IDX, 8'h04);
        @(negedge clk);
        snap = cnt;
        pulse_t0();
        chk("t0 step", snap + 16'h1, cnt);
        wr(CNT_MODE_IDX, 8'h06);
        // pin select is registered one edge after the mode register
        repeat (2) @(negedge clk);
        chk("alt ext", {8'h0, pused, 3'b100}, {8'h0, alt});
        snap = cnt;
        @(posedge clk) ext <= 1'b0;
        repeat (8) @(negedge clk);
        chk("ext fall", snap + 16'h1, cnt);
        @(posedge clk) ext <= 1'b1;
        repeat (8) @(negedge clk);
        chk("ext rise", snap + 16'h1, cnt);
        // wrap with overflow interrupt disabled first
        wr(CNT_MODE_IDX, 8'h04);
        @(posedge clk) t0 <= 1'b1;
        n = 0;
        while (cnt < 16'hfff0 && n < 70000) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk) t0 <= 1'b0;
        repeat (4) @(posedge clk);
        n = 0;
        while (cnt !== 16'h0000 && n < 40) begin
            pulse_t0();
            n++;
        end
        chk("wrap", 16'h0000, cnt);
        rd("ctrl ovf", CTRL_FLAGS_IDX, 8'hc0);
        chk("irq masked", 16'h0, {15'h0, airq});
        wr(CNT_MODE_IDX, 8'h05);
        repeat (3) @(negedge clk);
        chk("irq ovf", 16'h1, {15'h0, airq});
        repeat (50) @(posedge clk);
        rd("ctrl held", CTRL_FLAGS_IDX, 8'hc0);
        wr(CTRL_FLAGS_IDX, 8'h40);
        rd("ctrl clr", CTRL_FLAGS_IDX, 8'h40);
        chk("irq clr", 16'h0, {15'h0, airq});
        wr(CTRL_FLAGS_IDX, 8'hc0);
        rd("ctrl set", CTRL_FLAGS_IDX, 8'hc0);
        chk("irq sw", 16'h1, {15'h0, airq});
        wr(CTRL_FLAGS_IDX, 8'h40);
        // sticky status, enable and clear of the event interrupt
        wr(EVT_STATUS_IDX, 8'h3f);
        rd("status", EVT_STATUS_IDX, 8'h20);
        wr(EVT_ENABLE_IDX, 8'h20);
        repeat (2) @(negedge clk);
        chk("evt irq", 16'h1, {15'h0, eirq});
        wr(EVT_CLEAR_IDX, 8'h20);
        repeat (2) @(negedge clk);
        chk("evt irq clr", 16'h0, {15'h0, eirq});
        rd("status clr", EVT_STATUS_IDX, 8'h00);
        rd("clear reg", EVT_CLEAR_IDX, 8'h00);
        // module flags, gated by each module's own enable
        for (int m = 0; m < NUM_MODULES; m++) begin
            @(posedge clk) mev <= 5'h01 << m;
            @(posedge clk) mev <= 5'h00;
            repeat (3) @(posedge clk);
            rd("mod flag", CTRL_FLAGS_IDX, 8'h40 | (8'h01 << m));
            chk("mod masked", 16'h0, {15'h0, airq});
            @(posedge clk) mien <= 5'h01 << m;
            repeat (3) @(negedge clk);
            chk("mod irq", 16'h1, {15'h0, airq});
            wr(CTRL_FLAGS_IDX, 8'h5f);
            rd("mod keep", CTRL_FLAGS_IDX, 8'h40 | (8'h01 << m));
            wr(CTRL_FLAGS_IDX, 8'h40);
            repeat (2) @(negedge clk);
            chk("mod clr", 16'h0, {15'h0, airq});
            @(posedge clk) mien <= 5'h00;
        end
        rd("status mods", EVT_STATUS_IDX, 8'h1f);
        // reset in mid-run with the counter running and the watchdog on
        wr(CNT_MODE_IDX, 8'h42);
        repeat (20) @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        chk("count rst", COUNT_RST, cnt);
        chk("wdog rst", 16'h0, {15'h0, wdog});
        chk("irq rst", 16'h0, {15'h0, airq});
        rd("ctrl rst", CTRL_FLAGS_IDX, CTRL_FLAGS_RST);
        rd("mode rst", CNT_MODE_IDX, CNT_MODE_RST);
        conclude();
    end

    // the wrap alone needs about 65600 cycles, the rest a few hundred
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        conclude();
    end
endmodule

`default_nettype wire
